/* efc_defines.svh */
`ifndef EFC_DEFINES_SVH
`define EFC_DEFINES_SVH

// Register byte offsets on the AHB-Lite slave
`define OFS_ENHANCED_FEATURE 12'h000
`define OFS_INTERRUPT_ENABLE 12'h004
`define OFS_FIFO_CONTROL     12'h008
`define OFS_MODEM_CONTROL    12'h00c
`define OFS_INTERRUPT_IDENT  12'h010
`define OFS_RESUME_ONE       12'h014
`define OFS_RESUME_TWO       12'h018
`define OFS_PAUSE_ONE        12'h01c
`define OFS_PAUSE_TWO        12'h020
`define OFS_RX_CHAR          12'h024
`define OFS_FLOW_STATUS      12'h028

// Field positions
`define EFR_UNLOCK_BIT   4
`define EFR_SPECIAL_BIT  5
`define IER_GUARD_MASK   8'hf0
`define FCR_GUARD_MASK   8'h30
`define MCR_GUARD_MASK   8'he0

// Reset values
`define RST_BYTE         8'h00
`define RST_IDENT        8'h01

// Flow select encodings on bits 3:0
`define SEL_DUAL_SEQ     4'hf
`define SEL_EITHER       4'hb

`endif

/* efc_pkg.sv */
`default_nettype none

package efc_pkg;
    // One received character offered to the comparator
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rx_char_t;

    // Outcome of the flow-control comparator
    typedef struct packed {
        logic resume;
        logic pause;
        logic special;
    } flow_event_t;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_ON1   = 2'b01,
        SEQ_OFF1  = 2'b10
    } seq_state_t;
endpackage : efc_pkg

`default_nettype wire

/* efc_flow_match.sv */
`timescale 1ns/1ps
`default_nettype none
`include "efc_defines.svh"

module efc_flow_match (
    input  wire logic                CLK,
    input  wire logic                RST,
    input  wire logic [3:0]          SEL,
    input  wire logic                SPECIAL_EN,
    input  wire logic [7:0]          RESUME_ONE,
    input  wire logic [7:0]          RESUME_TWO,
    input  wire logic [7:0]          PAUSE_ONE,
    input  wire logic [7:0]          PAUSE_TWO,
    input  wire efc_pkg::rx_char_t   RX,
    output var  efc_pkg::flow_event_t EVT
);
    import efc_pkg::*;

    seq_state_t  state_reg;
    seq_state_t  state_next;
    flow_event_t evt_reg;
    flow_event_t evt_next;

    // ----------------------------------------
    // Character compare
    // ----------------------------------------
    wire on1  = RX.data == RESUME_ONE;
    wire on2  = RX.data == RESUME_TWO;
    wire off1 = RX.data == PAUSE_ONE;
    wire off2 = RX.data == PAUSE_TWO;
    wire dual   = SEL == `SEL_DUAL_SEQ;
    wire either = SEL == `SEL_EITHER;
    wire only1  = (SEL[1:0] == 2'b10) && !dual && !either;
    wire only2  = (SEL[1:0] == 2'b01) && !dual && !either;

    // Matching per mode
    always_comb begin
        state_next = state_reg;
        evt_next   = '0;
        if (RX.valid) begin
            evt_next.special = SPECIAL_EN && off2;
            unique case (1'b1)
                dual: begin
                    state_next = SEQ_IDLE;
                    if (state_reg == SEQ_ON1 && on2) evt_next.resume = 1'b1;
                    else if (state_reg == SEQ_OFF1 && off2) evt_next.pause = 1'b1;
                    else if (on1) state_next = SEQ_ON1;
                    else if (off1) state_next = SEQ_OFF1;
                end
                either: begin
                    evt_next.resume = on1 || on2;
                    evt_next.pause  = off1 || off2;
                end
                only1: begin
                    evt_next.resume = on1;
                    evt_next.pause  = off1;
                end
                only2: begin
                    evt_next.resume = on2;
                    evt_next.pause  = off2;
                end
                default: begin
                    state_next = SEQ_IDLE;
                end
            endcase
        end
    end

    // State and result registers
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg <= SEQ_IDLE;
            evt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            evt_reg   <= evt_next;
        end
    end

    assign EVT = evt_reg;
endmodule : efc_flow_match

`default_nettype wire

/* uart_enhanced_feature_control.sv */
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "efc_defines.svh"

module uart_enhanced_feature_control (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        HSEL,
    input  wire logic [11:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic [7:0]       INTERRUPT_ENABLE,
    output logic [7:0]       FIFO_CONTROL,
    output logic [7:0]       MODEM_CONTROL,
    output logic [3:0]       FLOW_SELECT,
    output logic             RESUME_EVENT,
    output logic             PAUSE_EVENT,
    output logic             SPECIAL_EVENT
);
    import efc_pkg::*;

    // ----------------------------------------
    // Bus address phase capture
    // ----------------------------------------
    logic        wr_pend_reg;
    logic [11:0] addr_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    wire        take      = HSEL && HREADY && HTRANS[1];
    wire        take_wr   = take && HWRITE;
    wire        take_rd   = take && !HWRITE;
    wire [7:0]  wbyte     = HWDATA[7:0];

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wr_pend_reg <= 1'b0;
            addr_reg    <= 12'h000;
        end else if (HREADY) begin
            wr_pend_reg <= take_wr;
            addr_reg    <= HADDR;
        end
    end

    // Write strobes in the data phase
    wire we_efr  = wr_pend_reg && addr_reg == `OFS_ENHANCED_FEATURE;
    wire we_ier  = wr_pend_reg && addr_reg == `OFS_INTERRUPT_ENABLE;
    wire we_fcr  = wr_pend_reg && addr_reg == `OFS_FIFO_CONTROL;
    wire we_mcr  = wr_pend_reg && addr_reg == `OFS_MODEM_CONTROL;
    wire we_iir  = wr_pend_reg && addr_reg == `OFS_INTERRUPT_IDENT;
    wire we_on1  = wr_pend_reg && addr_reg == `OFS_RESUME_ONE;
    wire we_on2  = wr_pend_reg && addr_reg == `OFS_RESUME_TWO;
    wire we_off1 = wr_pend_reg && addr_reg == `OFS_PAUSE_ONE;
    wire we_off2 = wr_pend_reg && addr_reg == `OFS_PAUSE_TWO;
    wire we_rx   = wr_pend_reg && addr_reg == `OFS_RX_CHAR;

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [7:0] enhanced_feature_reg;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] fifo_control_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] interrupt_ident_reg;
    logic [7:0] resume_char_one;
    logic [7:0] resume_char_two;
    logic [7:0] pause_char_one;
    logic [7:0] pause_char_two;
    logic [2:0] flow_sticky_reg;
    logic [2:0] flow_sticky_next;
    rx_char_t   rx_char_reg;
    flow_event_t evt;

    wire unlock = enhanced_feature_reg[`EFR_UNLOCK_BIT];

    // Guard mask: enhanced bits pass only while unlocked
    wire [7:0] ier_mask = unlock ? 8'hff : ~`IER_GUARD_MASK;
    wire [7:0] fcr_mask = unlock ? 8'hff : ~`FCR_GUARD_MASK;
    wire [7:0] mcr_mask = unlock ? 8'hff : ~`MCR_GUARD_MASK;

    // Merge of written byte with held guarded bits
    wire [7:0] ier_next = (wbyte & ier_mask) | (interrupt_enable_reg & ~ier_mask);
    wire [7:0] fcr_next = (wbyte & fcr_mask) | (fifo_control_reg & ~fcr_mask);
    wire [7:0] mcr_next = (wbyte & mcr_mask) | (modem_control_reg & ~mcr_mask);

    // Sticky flow events: a new event wins over a software clear
    assign flow_sticky_next = (we_iir ? (flow_sticky_reg & ~wbyte[2:0]) : flow_sticky_reg)
                            | {evt.special, evt.pause, evt.resume};

    // Software registers; guarded bits hold their latched value once locked
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            enhanced_feature_reg <= `RST_BYTE;
            interrupt_enable_reg <= `RST_BYTE;
            fifo_control_reg     <= `RST_BYTE;
            modem_control_reg    <= `RST_BYTE;
            resume_char_one      <= `RST_BYTE;
            resume_char_two      <= `RST_BYTE;
            pause_char_one       <= `RST_BYTE;
            pause_char_two       <= `RST_BYTE;
        end else begin
            if (we_efr)  enhanced_feature_reg <= wbyte;
            if (we_ier)  interrupt_enable_reg <= ier_next;
            if (we_fcr)  fifo_control_reg     <= fcr_next;
            if (we_mcr)  modem_control_reg    <= mcr_next;
            if (we_on1)  resume_char_one      <= wbyte;
            if (we_on2)  resume_char_two      <= wbyte;
            if (we_off1) pause_char_one       <= wbyte;
            if (we_off2) pause_char_two       <= wbyte;
        end
    end

    // Status and test character path
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            flow_sticky_reg <= 3'h0;
            rx_char_reg     <= '0;
        end else begin
            flow_sticky_reg   <= flow_sticky_next;
            rx_char_reg.valid <= we_rx;
            if (we_rx) rx_char_reg.data <= wbyte;
        end
    end

    // Ident: bit 4 reports special character when its interrupt is enabled
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            interrupt_ident_reg <= `RST_IDENT;
        end else begin
            interrupt_ident_reg <= {2'b00, 1'b0,
                                    flow_sticky_next[2] & interrupt_enable_reg[5],
                                    4'(`RST_IDENT)};
        end
    end

    // ----------------------------------------
    // Receive flow-control comparator
    // ----------------------------------------
    efc_flow_match u_match (
        .CLK        (CLK),
        .RST        (RST),
        .SEL        (enhanced_feature_reg[3:0]),
        .SPECIAL_EN (enhanced_feature_reg[`EFR_SPECIAL_BIT]),
        .RESUME_ONE (resume_char_one),
        .RESUME_TWO (resume_char_two),
        .PAUSE_ONE  (pause_char_one),
        .PAUSE_TWO  (pause_char_two),
        .RX         (rx_char_reg),
        .EVT        (evt)
    );

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (HADDR)
            `OFS_ENHANCED_FEATURE: rdata_next[7:0] = enhanced_feature_reg;
            `OFS_INTERRUPT_ENABLE: rdata_next[7:0] = interrupt_enable_reg;
            `OFS_FIFO_CONTROL:     rdata_next[7:0] = fifo_control_reg;
            `OFS_MODEM_CONTROL:    rdata_next[7:0] = modem_control_reg;
            `OFS_INTERRUPT_IDENT:  rdata_next[7:0] = interrupt_ident_reg;
            `OFS_RESUME_ONE:       rdata_next[7:0] = resume_char_one;
            `OFS_RESUME_TWO:       rdata_next[7:0] = resume_char_two;
            `OFS_PAUSE_ONE:        rdata_next[7:0] = pause_char_one;
            `OFS_PAUSE_TWO:        rdata_next[7:0] = pause_char_two;
            `OFS_FLOW_STATUS:      rdata_next[2:0] = flow_sticky_reg;
            default:               rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_reg <= 32'h0000_0000;
        end else if (take_rd) begin
            rdata_reg <= rdata_next;
        end
    end

    // Outputs
    assign HRDATA           = rdata_reg;
    assign HREADYOUT        = 1'b1;
    assign HRESP            = 1'b0;
    assign INTERRUPT_ENABLE = interrupt_enable_reg;
    assign FIFO_CONTROL     = fifo_control_reg;
    assign MODEM_CONTROL    = modem_control_reg;
    assign FLOW_SELECT      = enhanced_feature_reg[3:0];
    assign RESUME_EVENT     = evt.resume;
    assign PAUSE_EVENT      = evt.pause;
    assign SPECIAL_EVENT    = evt.special;
endmodule : uart_enhanced_feature_control

`default_nettype wire

/* efc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "efc_defines.svh"

module efc_checker (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        HSEL,
    input wire logic [11:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic [7:0]  INTERRUPT_ENABLE,
    input wire logic [7:0]  FIFO_CONTROL,
    input wire logic [7:0]  MODEM_CONTROL,
    input wire logic [3:0]  FLOW_SELECT,
    input wire logic        RESUME_EVENT,
    input wire logic        PAUSE_EVENT,
    input wire logic        SPECIAL_EVENT
);
    logic        dp_wr_reg;
    logic [11:0] dp_addr_reg;
    logic        unlock_reg;
    logic        special_reg;
    // Data-phase write decodes
    wire wr_fe = dp_wr_reg && dp_addr_reg == `OFS_ENHANCED_FEATURE;
    wire wr_ie = dp_wr_reg && dp_addr_reg == `OFS_INTERRUPT_ENABLE;
    wire wr_fc = dp_wr_reg && dp_addr_reg == `OFS_FIFO_CONTROL;
    wire wr_mc = dp_wr_reg && dp_addr_reg == `OFS_MODEM_CONTROL;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // Track the data phase and the unlock and special bits
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            dp_wr_reg   <= 1'b0;
            dp_addr_reg <= 12'h000;
            unlock_reg  <= 1'b0;
            special_reg <= 1'b0;
        end else begin
            dp_wr_reg   <= HSEL && HREADY && HTRANS[1] && HWRITE;
            dp_addr_reg <= HADDR;
            unlock_reg  <= wr_fe ? HWDATA[4] : unlock_reg;
            special_reg <= wr_fe ? HWDATA[5] : special_reg;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    ready_high_a: assert property (HREADYOUT)
        else $error("slave inserted a wait state");
    resp_okay_a: assert property (!HRESP)
        else $error("slave gave an error response");
    reset_clear_a: assert property ($fell(RST) |->
        {INTERRUPT_ENABLE, FIFO_CONTROL, MODEM_CONTROL, FLOW_SELECT} == 28'h0)
        else $error("outputs not cleared by reset");
    ie_unlocked_a: assert property (wr_ie && unlock_reg |=>
        INTERRUPT_ENABLE == $past(HWDATA[7:0])) else $error("unlocked enable write lost");
    fc_unlocked_a: assert property (wr_fc && unlock_reg |=>
        FIFO_CONTROL == $past(HWDATA[7:0])) else $error("unlocked fifo write lost");
    ie_locked_a: assert property (wr_ie && !unlock_reg |=>
        INTERRUPT_ENABLE == {$past(INTERRUPT_ENABLE[7:4]), $past(HWDATA[3:0])})
        else $error("locked enable write wrong");
    mc_locked_a: assert property (wr_mc && !unlock_reg |=>
        $stable(MODEM_CONTROL[7:5])) else $error("locked modem bits changed");
    no_flow_a: assert property ((FLOW_SELECT == 4'h0) [*3] |->
        !(RESUME_EVENT || PAUSE_EVENT)) else $error("flow event with control off");
    no_special_a: assert property ((!special_reg) [*3] |->
        !SPECIAL_EVENT) else $error("special event while disabled");
endmodule : efc_checker

bind uart_enhanced_feature_control efc_checker u_chk (.CLK(CLK), .RST(RST), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .INTERRUPT_ENABLE(INTERRUPT_ENABLE),
    .FIFO_CONTROL(FIFO_CONTROL), .MODEM_CONTROL(MODEM_CONTROL), .FLOW_SELECT(FLOW_SELECT),
    .RESUME_EVENT(RESUME_EVENT), .PAUSE_EVENT(PAUSE_EVENT), .SPECIAL_EVENT(SPECIAL_EVENT));
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "efc_defines.svh"

module tb_top;
    import efc_pkg::*;
    logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp, rev, pev, sev;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, r;
    logic [7:0]  ie, fc, mc, c, prev;
    logic [7:0]  reg_m[4], gm[4], ch[4], md[6];
    logic [3:0]  fs;
    logic [2:0]  f, st;
    int          err_count, cmp_count, seed, i, k;
    int          idx[8] = '{0, 0, 1, 2, 3, 0, 1, 3};

    assign hready = hreadyout;
    uart_enhanced_feature_control dut (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .INTERRUPT_ENABLE(ie),
        .FIFO_CONTROL(fc), .MODEM_CONTROL(mc), .FLOW_SELECT(fs), .RESUME_EVENT(rev),
        .PAUSE_EVENT(pev), .SPECIAL_EVENT(sev));

    // ------------------------------------------------------------
    // Clock, tasks and model
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task report_and_stop;
        if (err_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // One AHB-Lite single word transfer, waits on hready in both phases
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, {r[31:8], d});
        if (a < 12'h010)
            reg_m[a[3:2]] = reg_m[0][4] ? d : (reg_m[a[3:2]] & gm[a[3:2]]) | (d & ~gm[a[3:2]]);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, r);
        chk(hrdata, exp);
    endtask : rd

    task check_outs;
        #1;
        chk(ie, reg_m[1]);
        chk(fc, reg_m[2]);
        chk(mc, reg_m[3]);
        chk(fs, reg_m[0][3:0]);
    endtask : check_outs

    function automatic logic [1:0] fexp(input logic [3:0] s, input logic [7:0] p, input logic [7:0] x);
        case (s)
            4'hf: return {p == ch[0] && x == ch[1], p == ch[2] && x == ch[3]};
            4'hb: return {x == ch[0] || x == ch[1], x == ch[2] || x == ch[3]};
            default: return s[1:0] == 2'b10 ? {x == ch[0], x == ch[2]} :
                            s[1:0] == 2'b01 ? {x == ch[1], x == ch[3]} : 2'b00;
        endcase
    endfunction : fexp

    // Watchdog
    initial begin
        #100000;
        err_count++;
        report_and_stop;
    end

    // Main sequence
    initial begin
        seed = 32'hc45f;
        {err_count, cmp_count, r} = '0;
        {rst, hsel, haddr, htrans, hwrite, hsize, hwdata} = {1'b1, 16'h0, 3'b010, 32'h0};
        reg_m = '{default: 8'h00};
        gm = '{8'h00, 8'hf0, 8'h30, 8'he0};
        md = '{8'h0f, 8'h0b, 8'h02, 8'h01, 8'h00, 8'h20};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check_outs;
        rd(`OFS_INTERRUPT_IDENT, 32'h01);
        for (i = 0; i < 24; i++) begin
            r = $random(seed);
            wr(`OFS_ENHANCED_FEATURE, {r[7:6], 1'b0, i[0], r[3:0]});
            for (k = 1; k < 4; k++)
                wr(12'(4 * k), r[8 * k +: 8]);
            check_outs;
            for (k = 0; k < 4; k++)
                rd(12'(4 * k), {24'h0, reg_m[k]});
        end
        wr(12'h02c, r[7:0]);
        check_outs;
        rd(12'h02c, 32'h0);
        for (k = 0; k < 4; k++) begin
            r = $random(seed);
            ch[k] = {k[1:0], 1'b1, r[4:0]};
            wr(`OFS_RESUME_ONE + 12'(4 * k), ch[k]);
        end
        // Every select mode, then special detect, over one awkward sequence
        st = 3'b000;
        for (k = 0; k < 6; k++) begin
            wr(`OFS_ENHANCED_FEATURE, md[k]);
            prev = 8'h00;
            for (i = 0; i < 8; i++) begin
                c = (i == 0 || i == 5) ? 8'h00 : ch[idx[i]];
                wr(`OFS_RX_CHAR, c);
                @(posedge clk);
                #1;
                f = {fexp(reg_m[0][3:0], prev, c), reg_m[0][5] && c == ch[3]};
                chk({rev, pev, sev}, f);
                st = st | {f[0], f[1], f[2]};
                prev = c;
            end
        end
        // Sticky status, ident report, and write-one clear
        rd(`OFS_FLOW_STATUS, {29'h0, st});
        rd(`OFS_INTERRUPT_IDENT, {27'h0, st[2] & reg_m[1][5], 4'h1});
        wr(`OFS_INTERRUPT_IDENT, 8'h07);
        rd(`OFS_FLOW_STATUS, 32'h0);
        report_and_stop;
    end
endmodule : tb_top
`default_nettype wire
